// >>> lwt_watchdog_timer.sv
// Purpose: Watchdog timer with one 8-bit control register on the special
//   function register port, counting low-frequency oscillator periods
// Assumes: rst_b is the system reset; wdt_reset_q feeds the system reset
// Notes: Register writes take effect one clock after the strobe
// Contract
// R1 - Timeout counter advances on oscillator ticks, not system clocks.
// R2 - Overflow while active requests full system reset.
// R3 - Watchdog reset never drives the external reset pin.
// R4 - After reset: active, counting, longest interval, lockout cleared.
// R5 - While active, the oscillator is forced on.
// R6 - Writing 0xA5 activates the watchdog and clears the counter.
// R7 - Software writes 0xA5 often enough to avoid overflow.
// R8 - 0xDE then 0xAD within 4 clocks disables; later is ignored.
// R9 - Software blocks interrupts across the disable sequence.
// R10 - 0xFF sets lockout; disables ignored until next reset.
// R11 - 0xFF alone neither activates nor clears the counter.
// R12 - Software wanting permanent watchdog writes 0xFF at init.
// R13 - Timeout is oscillator period times 4 to the (field plus 3).
// R14 - Interval loads only from writes with bit 7 clear.
// R15 - Reads return the programmed interval in bits 2:0.
// R16 - Interval field reads 111b after reset.
// R17 - Read bit 4 shows the active state.
// R18 - Other bit-7 writes change nothing and break a pending disable.
`timescale 1ns/1ps
module lwt_watchdog_timer #(
  parameter int LFO_DIV = lwt_pkg::LFO_DIV
) (
  input wire logic clk, // System clock, 200 MHz
  input wire logic rst_b, // System reset, async, active low
  input wire logic [7:0] sfr_addr, // Register address
  input wire logic sfr_wr, // Write strobe, one cycle
  input wire logic sfr_rd, // Read strobe, one cycle
  input wire logic [7:0] sfr_wdata, // Write data
  input wire logic lfo_stop_req, // Other request to stop the oscillator
  output logic [7:0] sfr_rdata, // Read data, valid the cycle after sfr_rd
  output logic wdt_reset_q, // System reset request, held until reset
  output logic lfo_run_q, // Oscillator run enable
  output logic rst_pin_oe_q // External reset pin drive enable
);
  // ========================================================================
  // Checks
  generate
    if (LFO_DIV < 2) begin : g_bad_div
      $error("lwt_watchdog_timer: LFO_DIV must be at least 2");
    end
  endgenerate

  // ========================================================================
  // State
  logic active_q;
  logic locked_q;
  logic [lwt_pkg::SEL_W-1:0] sel_q;
  logic [2:0] arm_q;
  logic [lwt_pkg::CNT_W-1:0] count_q;
  logic tick;

  // ========================================================================
  // Oscillator tick
  lwt_tick_gen #(.DIV(LFO_DIV)) u_tick (
    .clk(clk),
    .rst_b(rst_b),
    .en(lfo_run_q),
    .tick(tick)
  );

  // ========================================================================
  // Write decode
  wire hit = (sfr_addr == lwt_pkg::CTRL_ADDR);
  wire wr = sfr_wr & hit;
  wire rd = sfr_rd & hit;
  wire wr_sel = wr & ~sfr_wdata[lwt_pkg::CMD_BIT];
  wire wr_restart = wr & (sfr_wdata == lwt_pkg::CMD_RESTART);
  wire wr_lock = wr & (sfr_wdata == lwt_pkg::CMD_LOCK);
  wire wr_first = wr & (sfr_wdata == lwt_pkg::CMD_DIS_FIRST);
  wire wr_second = wr & (sfr_wdata == lwt_pkg::CMD_DIS_SECOND);
  wire armed = (arm_q != 3'h0);
  wire do_disable = wr_second & armed & ~locked_q; // R8 R10

  // Terminal count is 4^(sel+3) ticks, i.e. 2^(2*(sel+3))
  wire [5:0] shift = 6'((int'(sel_q) + lwt_pkg::SEL_BIAS) * 2); // R13
  wire [lwt_pkg::CNT_W-1:0] limit = (lwt_pkg::CNT_W)'(1) << shift; // R13
  wire overflow = active_q & tick & (count_q == limit - 1'b1); // R2

  wire [7:0] rd_value = {3'h0, active_q, 1'b0, sel_q}; // R15 R17

  // ========================================================================
  // Control register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      active_q <= 1'b1; // R4
      locked_q <= 1'b0; // R4
      sel_q <= lwt_pkg::SEL_RESET; // R16
    end else begin
      if (wr_restart) begin
        active_q <= 1'b1; // R6
      end else if (do_disable) begin
        active_q <= 1'b0; // R8
      end
      if (wr_lock) begin
        locked_q <= 1'b1; // R10
      end
      if (wr_sel) begin
        sel_q <= sfr_wdata[lwt_pkg::SEL_W-1:0]; // R14
      end
    end
  end

  // Disable window: opens on the first code, any other write to this register closes it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      arm_q <= 3'h0;
    end else if (wr_first) begin
      arm_q <= lwt_pkg::DIS_WINDOW; // R8
    end else if (wr) begin
      arm_q <= 3'h0; // R18
    end else if (armed) begin
      arm_q <= arm_q - 3'h1; // R8
    end
  end

  // ========================================================================
  // Timeout counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      count_q <= '0;
    end else if (wr_restart || !active_q) begin
      count_q <= '0; // R6
    end else if (tick && !wdt_reset_q) begin
      count_q <= count_q + 1'b1; // R1
    end
  end

  // ========================================================================
  // Outputs
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wdt_reset_q <= 1'b0;
      lfo_run_q <= 1'b1;
      rst_pin_oe_q <= 1'b0;
      sfr_rdata <= lwt_pkg::CTRL_RESET;
    end else begin
      if (overflow) begin
        wdt_reset_q <= 1'b1; // R2
      end
      lfo_run_q <= active_q | ~lfo_stop_req; // R5
      rst_pin_oe_q <= 1'b0; // R3
      if (rd) begin
        sfr_rdata <= rd_value;
      end
    end
  end

  // ========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  // ========================================================================
  // Restart and lockout

  a_restart_clears: assert property (wr_restart |=> active_q && count_q == '0) // R6
    else $error("restart did not activate and clear");

  a_restart_no_sel: assert property (wr_restart |=> $stable(sel_q) && $stable(locked_q)) // R6
    else $error("restart changed interval or lockout");

  a_restart_locked: assert property (wr_restart && locked_q |=> active_q) // R6 R10
    else $error("restart ignored while locked");

  a_lock_no_start: assert property (wr_lock && !active_q |=> !active_q) // R11
    else $error("lock write activated the watchdog");

  a_lock_count_kept: assert property (wr_lock && active_q && !tick |=> $stable(count_q)) // R11
    else $error("lock write changed the counter");

  a_lock_blocks_off: assert property (locked_q && wr_second |=> active_q || $past(!active_q)) // R10
    else $error("disable taken while locked");

  a_lock_sticky: assert property (locked_q |=> locked_q) // R10
    else $error("lockout cleared without reset");

  a_lock_set: assert property (wr_lock |=> locked_q) // R10
    else $error("lock write did not set lockout");

  a_unlock_kept: assert property (!locked_q && !wr_lock |=> !locked_q) // R10
    else $error("lockout set without lock write");

  a_active_kept: assert property (active_q && !do_disable |=> active_q) // R10 R11
    else $error("watchdog stopped without disable");

  a_inactive_kept: assert property (!active_q && !wr_restart |=> !active_q) // R11 R14
    else $error("watchdog started without restart");

  // ========================================================================
  // Disable sequence

  a_disable_window: assert property (
    wr_first ##1 (!wr) [*3] ##1 (wr_second && !locked_q) |=> !active_q) // R8
    else $error("disable within window ignored");

  a_disable_late: assert property (
    wr_first && active_q ##1 (!wr) [*4] ##1 wr_second |=> active_q) // R8
    else $error("late disable taken");

  a_disable_off: assert property (do_disable |=> !active_q) // R8
    else $error("disable did not stop the watchdog");

  a_second_alone: assert property (wr_second && !armed && active_q |=> active_q) // R8
    else $error("second code alone disabled");

  a_first_arms: assert property (wr_first |=> armed) // R8
    else $error("first code did not open the window");

  a_first_no_state: assert property (wr_first |=> $stable(active_q) && $stable(sel_q) && $stable(locked_q)) // R8
    else $error("first code changed state");

  a_second_no_sel: assert property (wr_second |=> $stable(sel_q) && $stable(locked_q)) // R8
    else $error("second code changed interval or lockout");

  a_arm_count: assert property (armed && !wr |=> arm_q == $past(arm_q) - 3'h1) // R8
    else $error("disable window did not count down");

  a_arm_cleared: assert property (wr && !wr_first |=> !armed) // R8 R18
    else $error("other write left the window open");

  a_bad_cmd_keep: assert property (wr && sfr_wdata[7] && !wr_restart && !wr_lock && !wr_second && !wr_first
    |=> $stable(sel_q) && $stable(active_q) && $stable(locked_q) && !armed) // R18
    else $error("undefined command changed state");

  // ========================================================================
  // Interval and counter

  a_sel_load: assert property (wr_sel |=> sel_q == $past(sfr_wdata[2:0])) // R14
    else $error("interval not loaded");

  a_sel_kept: assert property (!wr_sel |=> $stable(sel_q)) // R14
    else $error("interval changed without a load");

  a_sel_no_start: assert property (wr_sel && !active_q |=> !active_q) // R14
    else $error("interval write activated the watchdog");

  a_sel_no_clear: assert property (wr_sel && active_q && !tick |=> $stable(count_q)) // R14
    else $error("interval write changed the counter");

  a_count_on_tick: assert property (!tick && !wr_restart |=> $stable(count_q) || count_q == '0) // R1
    else $error("counter moved without oscillator tick");

  a_count_step: assert property (active_q && tick && !wr_restart && !wdt_reset_q
    |=> count_q == $past(count_q) + 1'b1) // R1
    else $error("counter missed an oscillator tick");

  a_count_idle: assert property (!active_q |=> count_q == '0) // R1
    else $error("counter kept value while inactive");

  a_count_stops: assert property (wdt_reset_q && active_q && !wr_restart |=> $stable(count_q)) // R2
    else $error("counter ran after reset request");

  a_tick_needs_lfo: assert property (tick |-> $past(lfo_run_q)) // R1
    else $error("tick without running oscillator");

  a_tick_single: assert property (tick |=> !tick) // R1
    else $error("tick longer than one cycle");

  // ========================================================================
  // Outputs

  a_overflow_reset: assert property (overflow |=> wdt_reset_q) // R2 R13
    else $error("overflow did not request reset");

  a_reset_sticky: assert property (wdt_reset_q |=> wdt_reset_q) // R2
    else $error("reset request dropped");

  a_reset_cause: assert property (!overflow && !wdt_reset_q |=> !wdt_reset_q) // R2
    else $error("reset request without overflow");

  a_lfo_forced: assert property (active_q |=> lfo_run_q) // R5
    else $error("oscillator stopped while active");

  a_lfo_free: assert property (!lfo_stop_req |=> lfo_run_q) // R5
    else $error("oscillator stopped without request");

  a_lfo_stops: assert property (!active_q && lfo_stop_req |=> !lfo_run_q) // R5
    else $error("stop request ignored while inactive");

  a_pin_quiet: assert property (!rst_pin_oe_q) // R3
    else $error("reset pin driven");

  // ========================================================================
  // Read path

  a_read_back: assert property (rd |=> sfr_rdata == $past(rd_value)) // R15 R17
    else $error("read value wrong");

  a_read_sel: assert property (rd |=> sfr_rdata[2:0] == $past(sel_q)) // R15
    else $error("read interval wrong");

  a_read_active: assert property (rd |=> sfr_rdata[lwt_pkg::ACTIVE_BIT] == $past(active_q)) // R17
    else $error("read active flag wrong");

  a_read_zeros: assert property (rd |=> sfr_rdata[7:5] == 3'h0 && !sfr_rdata[3]) // R15
    else $error("read unused bits not zero");

  a_read_hold: assert property (!rd |=> $stable(sfr_rdata)) // R15
    else $error("read data changed without a read");

  // ========================================================================
  // Coverage

  c_restart: cover property (wr_restart);
  c_disable: cover property (do_disable);
  c_timeout: cover property (overflow);
  c_locked_try: cover property (locked_q && wr_second && armed);
  c_lock: cover property (wr_lock && active_q);
endmodule

// >>> lwt_pkg.sv
// Purpose: Shared constants for the low-frequency-oscillator watchdog timer
// Assumes: 200 MHz system clock, 80 kHz low-frequency oscillator
// Notes: All command codes, field positions and reset values live here
// ==========================================================================
// Constants
package lwt_pkg;
  localparam logic [7:0] CTRL_ADDR = 8'h97;
  localparam logic [7:0] CTRL_RESET = 8'h17;
  localparam logic [7:0] CMD_RESTART = 8'hA5;
  localparam logic [7:0] CMD_DIS_FIRST = 8'hDE;
  localparam logic [7:0] CMD_DIS_SECOND = 8'hAD;
  localparam logic [7:0] CMD_LOCK = 8'hFF;
  localparam int CMD_BIT = 7;
  localparam int ACTIVE_BIT = 4;
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_RESET = 3'h7;
  localparam logic [2:0] DIS_WINDOW = 3'h4;
  localparam int SEL_BIAS = 3;
  localparam longint CLK_HZ = 200000000;
  localparam longint LFO_HZ = 80000;
  localparam int LFO_DIV = int'(CLK_HZ / LFO_HZ);
  localparam int CNT_W = 2 * (SEL_BIAS + 7) + 1;
endpackage

// >>> lwt_tick_gen.sv
// Purpose: Divider that turns the system clock into a one-cycle tick per
//   low-frequency oscillator period
// Assumes: DIV is the number of system clocks per oscillator period
// Notes: Tick runs only while enabled; phase restarts when disabled
`timescale 1ns/1ps
module lwt_tick_gen #(
  parameter int DIV = lwt_pkg::LFO_DIV
) (
  input wire logic clk, // System clock
  input wire logic rst_b, // Async reset, active low
  input wire logic en, // Oscillator running
  output logic tick // One-cycle tick per oscillator period
);
  // ========================================================================
  // Checks
  generate
    if (DIV < 2) begin : g_bad_div
      $error("lwt_tick_gen: DIV must be at least 2");
    end
  endgenerate

  // ========================================================================
  // Divider
  logic [$clog2(DIV)-1:0] div_q;
  wire div_wrap = (div_q == ($clog2(DIV))'(DIV - 1));

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= '0;
      tick <= 1'b0;
    end else begin
      tick <= en & div_wrap;
      if (!en || div_wrap) begin
        div_q <= '0;
      end else begin
        div_q <= div_q + 1'b1;
      end
    end
  end
endmodule

// >>> lwt_watchdog_timer_tb_top.sv
// Purpose: Self-checking bench for the watchdog timer control register and timeout
// Assumes: Oscillator divider shortened to 4 clocks; inputs driven on falling edges
// Notes: Timeout run uses the shortest interval, 64 ticks
`timescale 1ns/1ps
module lwt_watchdog_timer_tb_top;
  localparam int DIV = 4;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] sfr_addr = 8'h00;
  logic sfr_wr = 1'b0;
  logic sfr_rd = 1'b0;
  logic [7:0] sfr_wdata = 8'h00;
  logic lfo_stop_req = 1'b0;
  logic [7:0] sfr_rdata;
  logic wdt_reset_q;
  logic lfo_run_q;
  logic rst_pin_oe_q;
  int n_mismatch = 0;
  int samples_checked = 0;
  int cyc;

  lwt_watchdog_timer #(.LFO_DIV(DIV)) DUT (.clk(clk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .lfo_stop_req(lfo_stop_req), .sfr_rdata(sfr_rdata),
    .wdt_reset_q(wdt_reset_q), .lfo_run_q(lfo_run_q), .rst_pin_oe_q(rst_pin_oe_q));

  initial begin
    forever #2.5 clk = ~clk;
  end

  // ==========================================================================
  // Access tasks
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic do_reset();
    rst_b = 1'b0;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge clk);
    sfr_wr = 1'b0;
    @(negedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] exp);
    sfr_addr = lwt_pkg::CTRL_ADDR;
    sfr_rd = 1'b1;
    @(negedge clk);
    sfr_rd = 1'b0;
    @(negedge clk);
    chk(sfr_rdata, exp);
  endtask

  task automatic results();
    $display("mismatches=%0d checks=%0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  initial begin
    @(negedge clk);
    do_reset();
    rd_chk(lwt_pkg::CTRL_RESET);
    chk({7'h00, rst_pin_oe_q}, 8'h00);
    wr(lwt_pkg::CTRL_ADDR, 8'h00);
    rd_chk(8'h10);
    wr(lwt_pkg::CTRL_ADDR, 8'h83);
    wr(8'h96, 8'h05);
    rd_chk(8'h10);
    // Late second write is ignored
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_FIRST);
    repeat (3) @(negedge clk);
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_SECOND);
    rd_chk(8'h10);
    // Undefined command breaks the pair
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_FIRST);
    wr(lwt_pkg::CTRL_ADDR, 8'h83);
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_SECOND);
    rd_chk(8'h10);
    // Latest allowed spacing disables; stop request then honoured
    lfo_stop_req = 1'b1;
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_FIRST);
    repeat (2) @(negedge clk);
    chk({7'h00, lfo_run_q}, 8'h01);
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_SECOND);
    rd_chk(8'h00);
    chk({7'h00, lfo_run_q}, 8'h00);
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_LOCK);
    rd_chk(8'h00);
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_RESTART);
    rd_chk(8'h10);
    chk({7'h00, lfo_run_q}, 8'h01);
    // Lockout holds off a valid disable pair
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_FIRST);
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_SECOND);
    rd_chk(8'h10);
    // Periodic restarts keep the timer from expiring
    for (int i = 0; i < 6; i++) begin
      repeat (150) @(negedge clk);
      wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_RESTART);
    end
    chk({7'h00, wdt_reset_q}, 8'h00);
    // Expiry after 64 oscillator ticks
    cyc = 0;
    while (wdt_reset_q !== 1'b1 && cyc < 2000) begin
      @(negedge clk);
      cyc++;
    end
    chk({7'h00, wdt_reset_q}, 8'h01);
    chk({7'h00, (cyc >= 64 * DIV - 2 * DIV) && (cyc <= 64 * DIV + 2 * DIV)}, 8'h01);
    chk({7'h00, rst_pin_oe_q}, 8'h00);
    if (cyc >= 2000) results();
    // System reset clears the lockout and re-arms
    do_reset();
    chk({7'h00, wdt_reset_q}, 8'h00);
    rd_chk(lwt_pkg::CTRL_RESET);
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_FIRST);
    wr(lwt_pkg::CTRL_ADDR, lwt_pkg::CMD_DIS_SECOND);
    rd_chk(8'h07);
    results();
  end
endmodule
